// [design/tce_capture_channel.sv]
// One input-capture channel: pin events latch the reference timer count
`timescale 1ns/1ps

// What this block does
// - Event copies 16-bit timer into capture pair
// - Mode selects fall, rise, 4th, 16th rise
// - Capture sets the capture event flag
// - Flag stays set until software clears it
// - Newer capture overwrites unread held value
// - Mode change may raise flag; software clears
// - Prescaler held cleared when off or not capturing
// - Every reset clears the prescaler counter
// - Switching prescaler directly keeps its count
// - Instruction-clocked timer freezes during sleep
// - Captures keep working in sleep, external clock
// - Detector watches pin level whatever its direction
// - Zero control write clears compare output latch

module tce_capture_channel
    import tce_pkg::*;
#(
    parameter logic [MODE_W-1:0] CODE_FALL   = MODE_FALL,
    parameter logic [MODE_W-1:0] CODE_RISE   = MODE_RISE,
    parameter logic [MODE_W-1:0] CODE_RISE4  = MODE_RISE4,
    parameter logic [MODE_W-1:0] CODE_RISE16 = MODE_RISE16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire tce_bus_req_t      bus_req,
    output logic [DATA_W-1:0]      bus_rdata,
    // Capture pin
    input  wire logic              capture_input_pin,
    // Reference timer
    input  wire tce_timer_t        timer_count,
    input  wire logic              timer_ext_clock,
    output logic                   timer_freeze,
    // Power state
    input  wire logic              sleep,
    // Outputs
    output logic                   compare_latch,
    output logic                   capture_event,
    output logic                   irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0]  channel_control_reg;
        tce_timer_t         capture_value;
        logic               capture_event_flag;
        logic               capture_event_enable;
        logic [PRESC_W-1:0] presc;
        logic               cmp_latch;
        logic               fired;
        logic [DATA_W-1:0]  rdata;
    } tce_chan_state_t;

    tce_chan_state_t    st;
    tce_chan_state_t    next_st;
    tce_edge_t          edges;
    logic [MODE_W-1:0]  mode;
    logic               in_capture;
    logic               fire;
    logic               wr_ctrl;
    logic               wr_clear;

    // ------------------------------------------------------------
    // Pin front end
    // ------------------------------------------------------------
    // Pin level is sampled whatever drives it, so port writes count
    tce_pin_edge u_pin_edge (
        .clk       (clk),
        .rst       (rst),
        .pin_level (capture_input_pin),
        .edges     (edges)
    );

    // ------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------
    assign mode       = st.channel_control_reg[MODE_W-1:0];
    assign wr_ctrl    = bus_req.wr && (bus_req.addr == OFS_CONTROL);
    assign wr_clear   = bus_req.wr && (bus_req.addr == OFS_CLEAR) && bus_req.wdata[FLAG_BIT];

    // Only the four capture codes count; zero and all others are idle
    assign in_capture = (mode == CODE_FALL) || (mode == CODE_RISE) ||
                        (mode == CODE_RISE4) || (mode == CODE_RISE16);

    always_comb
    begin
        fire = 1'b0;
        if (mode == CODE_FALL)
        begin
            fire = edges.fall;
        end
        else if (mode == CODE_RISE)
        begin
            fire = edges.rise;
        end
        else if (mode == CODE_RISE4)
        begin
            fire = edges.rise && ((st.presc & DIV4_MASK) == DIV4_LAST);
        end
        else if (mode == CODE_RISE16)
        begin
            fire = edges.rise && (st.presc == DIV16_LAST);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st       = st;
        next_st.rdata = READ_ZERO;
        next_st.fired = fire;

        // Register writes
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                OFS_CONTROL:
                begin
                    next_st.channel_control_reg = bus_req.wdata;
                    if (bus_req.wdata == CTRL_RESET)
                    begin
                        next_st.cmp_latch = 1'b0;
                    end
                end
                OFS_CAP_LOW:
                begin
                    next_st.capture_value.timer_count_low = bus_req.wdata;
                end
                OFS_CAP_HIGH:
                begin
                    next_st.capture_value.timer_count_high = bus_req.wdata;
                end
                OFS_ENABLE:
                begin
                    next_st.capture_event_enable = bus_req.wdata[FLAG_BIT];
                end
                default:
                begin
                    next_st.channel_control_reg = st.channel_control_reg;
                end
            endcase
        end

        // Only software clears the flag
        if (wr_clear)
        begin
            next_st.capture_event_flag = 1'b0;
        end

        // Prescaler: held clear outside capture, kept across mode swaps
        if (!in_capture)
        begin
            next_st.presc = PRESC_RESET;
        end
        else if (edges.rise)
        begin
            next_st.presc = st.presc + PRESC_STEP;
        end

        // Capture wins over a same-cycle byte write or flag clear
        if (fire)
        begin
            next_st.capture_value      = timer_count;
            next_st.capture_event_flag = 1'b1;
        end

        // Register reads, answered next cycle
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                OFS_CONTROL:  next_st.rdata = st.channel_control_reg;
                OFS_CAP_LOW:  next_st.rdata = st.capture_value.timer_count_low;
                OFS_CAP_HIGH: next_st.rdata = st.capture_value.timer_count_high;
                OFS_STATUS:   next_st.rdata = {{(DATA_W-1){1'b0}}, st.capture_event_flag};
                OFS_ENABLE:   next_st.rdata = {{(DATA_W-1){1'b0}}, st.capture_event_enable};
                default:      next_st.rdata = READ_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Any reset clears the prescaler with the rest of the state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus_rdata     = st.rdata;
    assign compare_latch = st.cmp_latch;
    assign capture_event = st.fired;
    assign irq           = st.capture_event_flag && st.capture_event_enable;

    // Timer on the instruction clock stops in sleep; external keeps going
    assign timer_freeze  = sleep && !timer_ext_clock;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_capture_loads_timer: assert property (
        @(posedge clk) disable iff (rst)
        fire |=> (st.capture_value == $past(timer_count)))
        else $error("capture pair does not hold the timer count");

    a_falling_edge_fires: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CODE_FALL) && edges.fall |=> capture_event && st.capture_event_flag)
        else $error("falling edge in fall mode did not capture");

    a_rise4_skips_edges: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CODE_RISE4) && edges.rise && (st.presc[1:0] != 2'h3) |-> !fire)
        else $error("divide by four captured on a wrong edge");

    a_rising_ignored_fall: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CODE_FALL) && !edges.fall |=> !capture_event)
        else $error("fall mode captured without a falling edge");

    a_flag_set_capture: assert property (
        @(posedge clk) disable iff (rst)
        fire && wr_clear |=> st.capture_event_flag)
        else $error("clear in the capture cycle lost the flag");

    a_flag_stays_set: assert property (
        @(posedge clk) disable iff (rst)
        st.capture_event_flag && !wr_clear |=> st.capture_event_flag)
        else $error("capture flag dropped without a clear");

    a_overwrite_held: assert property (
        @(posedge clk) disable iff (rst)
        st.capture_event_flag && fire |=>
            (st.capture_value.timer_count_low == $past(timer_count.timer_count_low)))
        else $error("second capture did not overwrite held value");

    a_prescaler_idle: assert property (
        @(posedge clk) disable iff (rst)
        !in_capture |=> (st.presc == PRESC_RESET))
        else $error("prescaler not cleared outside capture");

    a_prescaler_kept: assert property (
        @(posedge clk) disable iff (rst)
        wr_ctrl && in_capture && !edges.rise |=> (st.presc == $past(st.presc)))
        else $error("prescaler disturbed by a mode write");

    a_latch_zero_write: assert property (
        @(posedge clk) disable iff (rst)
        wr_ctrl && (bus_req.wdata == CTRL_RESET) |=> !compare_latch ##1 (st.presc == PRESC_RESET))
        else $error("zero control write did not clear latch and prescaler");

    a_irq_from_flag: assert property (
        @(posedge clk) disable iff (rst)
        fire && st.capture_event_enable && !(bus_req.wr && bus_req.addr == OFS_ENABLE) |=> irq)
        else $error("enabled capture did not raise the interrupt");

    a_freeze_sleep: assert property (
        @(posedge clk) disable iff (rst)
        sleep && timer_ext_clock |-> !timer_freeze)
        else $error("external timer frozen in sleep");

    // ------------------------------------------------------------
    // Checks on counting, reads and power state
    // ------------------------------------------------------------

    a_rise_mode_fires: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CODE_RISE) && edges.rise |=> capture_event && st.capture_event_flag)
        else $error("rising edge in rise mode did not capture");

    a_rise16_skips_edges: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CODE_RISE16) && edges.rise && (st.presc != DIV16_LAST) |-> !fire)
        else $error("divide by sixteen captured on a wrong edge");

    a_rise16_fires: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CODE_RISE16) && edges.rise && (st.presc == DIV16_LAST) |=> capture_event)
        else $error("sixteenth rising edge did not capture");

    a_prescaler_counts: assert property (
        @(posedge clk) disable iff (rst)
        in_capture && edges.rise |=> (st.presc == $past(st.presc) + PRESC_STEP))
        else $error("prescaler missed a rising edge");

    a_idle_no_capture: assert property (
        @(posedge clk) disable iff (rst)
        !in_capture |-> !fire)
        else $error("capture taken outside a capture mode");

    a_event_one_cycle: assert property (
        @(posedge clk) disable iff (rst)
        capture_event |=> !capture_event)
        else $error("capture event pulse longer than one cycle");

    a_status_read_flag: assert property (
        @(posedge clk) disable iff (rst)
        bus_req.rd && (bus_req.addr == OFS_STATUS) |=>
            (bus_rdata[FLAG_BIT] == $past(st.capture_event_flag)))
        else $error("status read does not show the flag");

    a_value_held_idle: assert property (
        @(posedge clk) disable iff (rst)
        !fire && !bus_req.wr |=> $stable(st.capture_value))
        else $error("capture pair changed without capture or write");

    a_flag_falls_clear: assert property (
        @(posedge clk) disable iff (rst)
        $fell(st.capture_event_flag) |-> $past(wr_clear))
        else $error("capture flag fell without a clear write");

    a_freeze_instr_clk: assert property (
        @(posedge clk) disable iff (rst)
        sleep && !timer_ext_clock |-> timer_freeze)
        else $error("instruction clocked timer not frozen in sleep");

    a_awake_no_freeze: assert property (
        @(posedge clk) disable iff (rst)
        !sleep |-> !timer_freeze)
        else $error("timer frozen while awake");

endmodule

// [design/tce_pkg.sv]
// Shared constants and types for the timer event capture channel
package tce_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 8;
    localparam int TIMER_W = 16;
    localparam int MODE_W  = 4;
    localparam int PRESC_W = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONTROL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CAP_LOW  = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CAP_HIGH = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CLEAR    = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_ENABLE   = 4'h5;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int                 FLAG_BIT    = 0;
    localparam logic [DATA_W-1:0]  CTRL_RESET  = 8'h00;
    localparam logic [DATA_W-1:0]  READ_ZERO   = 8'h00;
    localparam logic [TIMER_W-1:0] CAP_RESET   = 16'h0000;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 4'h0;
    localparam logic [PRESC_W-1:0] PRESC_STEP  = 4'h1;

    // ------------------------------------------------------------
    // Mode codes of capture_mode_select
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_OFF    = 4'h0;
    localparam logic [MODE_W-1:0] MODE_FALL   = 4'h4;
    localparam logic [MODE_W-1:0] MODE_RISE   = 4'h5;
    localparam logic [MODE_W-1:0] MODE_RISE4  = 4'h6;
    localparam logic [MODE_W-1:0] MODE_RISE16 = 4'h7;

    // Prescaler count on which the Nth rising edge lands
    localparam logic [PRESC_W-1:0] DIV4_MASK = 4'h3;
    localparam logic [PRESC_W-1:0] DIV4_LAST = 4'h3;
    localparam logic [PRESC_W-1:0] DIV16_LAST = 4'hf;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tce_bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] timer_count_high;
        logic [DATA_W-1:0] timer_count_low;
    } tce_timer_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tce_edge_t;

endpackage

// [design/tce_pin_edge.sv]
// Pin synchroniser and edge detector for the capture input
`timescale 1ns/1ps

module tce_pin_edge
    import tce_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin level and registered edges
    input  wire logic pin_level,
    output tce_edge_t edges
);

    typedef struct packed {
        logic      meta;
        logic      sync;
        logic      last;
        tce_edge_t edges;
    } tce_edge_state_t;

    tce_edge_state_t st;
    tce_edge_state_t next_st;

    // ------------------------------------------------------------
    // Synchroniser and edge compare
    // ------------------------------------------------------------
    // First stage feeds only the second; edges look at later stages
    always_comb
    begin
        next_st            = st;
        next_st.meta       = pin_level;
        next_st.sync       = st.meta;
        next_st.last       = st.sync;
        next_st.edges.rise = st.sync & ~st.last;
        next_st.edges.fall = ~st.sync & st.last;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign edges = st.edges;

endmodule

// [tb/tce_pin_model.sv]
// Far-side model: capture pin driver and reference timer
`timescale 1ns/1ps

module tce_pin_model
    import tce_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Timer
    input  wire logic               freeze,
    input  wire logic [TIMER_W-1:0] seed,
    output tce_timer_t              timer,
    // Pin
    output logic                    pin
);
    logic [TIMER_W-1:0] cnt;

    // Ticks on clk only, so always synchronous to the channel
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= seed;
        else if (!freeze)
            cnt <= cnt + 16'h0001;
    end
    assign timer = tce_timer_t'(cnt);

    initial pin = 1'b0;

    // ------
    // Pulses: two cycles high, three low
    // ------
    // Stamps are the count seen at the edge that changes the pin
    task automatic pulses(input int n, output logic [15:0] tr, output logic [15:0] tf);
        repeat (n)
        begin
            @(posedge clk);
            pin <= 1'b1;
            tr = cnt;
            repeat (2) @(posedge clk);
            pin <= 1'b0;
            tf = cnt;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the capture channel
`timescale 1ns/1ps

module tb_top
    import tce_pkg::*;
;
    logic              clk, rst, pin, ext_clk, sleep_i;
    logic              frz, cl, cev, irq, rd_q;
    logic [7:0]        rdata;
    logic [15:0]       seed, tr, tf, e;
    logic [31:0]       lfsr;
    tce_bus_req_t      req;
    tce_timer_t        tmr;
    int                n_errors, n_tests, n_cap, cyc;
    logic [7:0]        q [$];
    logic [MODE_W-1:0] mtab [4] = '{MODE_FALL, MODE_RISE, MODE_RISE4, MODE_RISE16};
    int                ntab [4] = '{1, 2, 4, 16};

    tce_capture_channel dut (
        .clk(clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
        .capture_input_pin(pin), .timer_count(tmr), .timer_ext_clock(ext_clk),
        .timer_freeze(frz), .sleep(sleep_i), .compare_latch(cl),
        .capture_event(cev), .irq(irq)
    );

    tce_pin_model pm (
        .clk(clk), .rst(rst), .freeze(frz), .seed(seed), .timer(tmr), .pin(pin)
    );

    // ------
    // Helpers
    // ------
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        n_tests++;
        if (s !== x)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    task automatic test_done();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Expected data is noted here and judged by the monitor
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk);
        q.push_back(x);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
    endtask

    task automatic pc(input int n, input int x);
        int c0;
        c0 = n_cap;
        pm.pulses(n, tr, tf);
        repeat (6) @(posedge clk);
        chk(16'(n_cap - c0), 16'(x));
    endtask

    // Enable off across the switch, channel off first
    task automatic setmode(input logic [3:0] m);
        lfsr = step(lfsr);
        wr(OFS_ENABLE, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONTROL, {lfsr[7:4], m});
        wr(OFS_CLEAR, 8'h01);
        wr(OFS_ENABLE, 8'h01);
    endtask

    task automatic zeros();
        for (int a = 0; a < 10; a++)
            rd(4'(a), 8'h00);
        #1;
        chk(16'(cl), 16'h0000);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (rd_q)
            chk(16'(rdata), 16'(q.pop_front()));
        rd_q <= req.rd;
        if (cev === 1'b1)
            n_cap++;
        cyc++;
        if (cyc > 20000)
        begin
            n_errors++;
            test_done();
        end
    end

    // ------
    // Sequence
    // ------
    initial
    begin
        rst = 1'b1;
        req = '0;
        sleep_i = 1'b0;
        ext_clk = 1'b0;
        rd_q = 1'b0;
        n_errors = 0;
        n_tests = 0;
        n_cap = 0;
        cyc = 0;
        lfsr = 32'h0e16b438;
        seed = lfsr[15:0];
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        zeros();
        for (int a = 0; a < 10; a++)
        begin
            lfsr = step(lfsr);
            wr(4'(a), lfsr[7:0]);
            rd(4'(a), a < 3 ? lfsr[7:0] : a == 5 ? {7'h00, lfsr[0]} : 8'h00);
        end
        wr(OFS_CONTROL, 8'h00);
        #1;
        chk(16'(cl), 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            sleep_i <= k[0];
            ext_clk <= k[1];
            #1;
            chk(16'(frz), 16'(k == 1));
        end
        // Modes run asleep on the external timer clock
        for (int i = 0; i < 4; i++)
        begin
            setmode(mtab[i]);
            if (ntab[i] > 1)
                pc(ntab[i] - 1, i == 1);
            pc(1, 1);
            e = (i == 0 ? tf : tr) + 16'h0004;
            rd(OFS_CAP_LOW, e[7:0]);
            rd(OFS_CAP_HIGH, e[15:8]);
            rd(OFS_STATUS, 8'h01);
            #1;
            chk(16'(irq), 16'h0001);
        end
        repeat (50) @(posedge clk);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, 8'h01);
        wr(OFS_ENABLE, 8'h00);
        #1;
        chk(16'(irq), 16'h0000);
        wr(OFS_ENABLE, 8'h01);
        #1;
        chk(16'(irq), 16'h0001);
        wr(OFS_CLEAR, 8'h01);
        #1;
        chk(16'(irq), 16'h0000);
        rd(OFS_STATUS, 8'h00);
        @(posedge clk);
        sleep_i <= 1'b0;
        ext_clk <= 1'b0;
        setmode(MODE_RISE4);
        pc(2, 0);
        wr(OFS_CONTROL, {4'h0, MODE_RISE16});
        pc(13, 0);
        pc(1, 1);
        pc(2, 0);
        wr(OFS_CONTROL, 8'h08);
        pc(1, 0);
        wr(OFS_CONTROL, {4'h0, MODE_RISE4});
        pc(3, 0);
        pc(1, 1);
        pc(2, 0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        zeros();
        wr(OFS_CONTROL, {4'h0, MODE_RISE4});
        pc(3, 0);
        pc(1, 1);
        wr(OFS_CONTROL, {4'h0, MODE_RISE});
        wr(OFS_CLEAR, 8'h01);
        // Clear lands in the capture cycle; the set must win
        fork
            pm.pulses(1, tr, tf);
            begin
                repeat (3) @(posedge clk);
                wr(OFS_CLEAR, 8'h01);
            end
        join
        rd(OFS_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule
